// ### verilog/nsq_pkg.sv
// Constants and types of the NAND command sequencer
package nsq_pkg;
  localparam int CLK_NS = 5;
  localparam int T_PULSE_NS = 20;
  localparam int T_WB_NS = 100;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] CMD_WIN_TAG = 5'h0D;
  localparam logic [17:0] SRAM_TAG = 18'h08040;
  localparam logic [23:0] REG_PAGE = 24'h400E00;
  localparam logic [31:0] REG_BANK = 32'h400E001C;
  localparam logic [31:0] REG_CFG = 32'h400E0020;
  localparam logic [31:0] REG_ADDR5 = 32'h400E0024;
  localparam logic [31:0] REG_ECC_REF = 32'h400E0028;
  localparam logic [31:0] REG_ECC = 32'h400E002C;
  localparam int F_OP1 = 0;
  localparam int F_OP2 = 8;
  localparam int F_OP2_VALID = 16;
  localparam int F_NADDR = 17;
  localparam int F_DATA = 20;
  localparam int F_PROG = 21;
  localparam logic [2:0] MAX_ADDR = 3'h5;
  localparam logic [2:0] ADDR5_IDX = 3'h4;
  localparam int PAGE_MIN_BYTES = 512;
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam logic [15:0] ECC_RST = 16'h0000;
  localparam int ST_BUSY = 0;
  localparam int ST_PEND = 1;
  localparam int ST_OVF = 2;
  localparam int ST_RB = 3;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OP1 = 3'b001,
    S_ADDR = 3'b010,
    S_WDATA = 3'b011,
    S_OP2 = 3'b100,
    S_WAIT = 3'b101,
    S_RDATA = 3'b110,
    S_DRAIN = 3'b111
  } nsq_state_t;
  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_CMD = 2'b01,
    K_REG = 2'b10,
    K_SRAM = 2'b11
  } nsq_kind_t;
endpackage : nsq_pkg

// ### verilog/nsq_top.sv
// NAND command sequencer: page FIFO and top level
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps

module nsq_fifo import nsq_pkg::*; #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] cnt;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
  } nsq_fifo_st_t;
  nsq_fifo_st_t q;
  nsq_fifo_st_t d;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_out = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out = mem[q.rp];

  always_comb begin
    d = q;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem[q.wp] <= in_data_in;
    end
  end
endmodule : nsq_fifo

module nsq_top import nsq_pkg::*; #(
  parameter int NBANK = 8,
  parameter int SRAM_WORDS = 4096,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic nand_cle_out,
  output logic nand_ale_out,
  output logic nand_we_n_out,
  output logic nand_re_n_out,
  output logic [NBANK-1:0] nand_ce_n_out,
  input wire logic [15:0] nand_d_in,
  output logic [15:0] nand_d_out,
  output logic nand_d_oe_out,
  input wire logic nand_rb_in
);
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic dp_wr;
    nsq_kind_t dp_kind;
    logic [31:0] dp_addr;
    logic [2:0] bank;
    logic [1:0] psel;
    logic w16;
    logic [7:0] addr5;
    logic [15:0] ecc_ref;
    logic [15:0] ecc;
    logic pend;
    logic [31:0] pend_cmd;
    logic [31:0] pend_dat;
    logic ovf;
    nsq_state_t st;
    logic [31:0] cmd;
    logic [31:0] dat;
    logic [2:0] anum;
    logic [2:0] aidx;
    logic [1:0] ph;
    logic [4:0] tmr;
    logic [12:0] ncnt;
    logic [12:0] scnt;
    logic [15:0] dout;
    logic doe;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [NBANK-1:0] ce_n;
    logic rb_m;
    logic rb_s;
    logic [15:0] din_m;
    logic [15:0] din_s;
  } nsq_top_st_t;

  nsq_top_st_t q;
  nsq_top_st_t n;
  logic [15:0] sram_mem [SRAM_WORDS];
  logic s_we;
  logic [11:0] s_wa;
  logic [15:0] s_wd;
  logic f_in_v;
  logic f_in_r;
  logic [15:0] f_in_d;
  logic f_out_v;
  logic f_out_r;
  logic [15:0] f_out_d;
  logic aph;
  logic bus_sram;
  logic done;
  logic prog;
  logic xfer;
  nsq_kind_t kind;
  nsq_state_t after_addr;
  logic [12:0] words;
  logic [15:0] sample;
  logic [7:0] abyte;

  // Position parity of one word: bit offset xor, word index if odd
  function automatic logic [15:0] ecc_pos(input logic [11:0] idx, input logic [15:0] w);
    logic [3:0] b;
    logic p;
    b = 4'h0;
    p = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (w[i]) begin
        b = b ^ 4'(i);
        p = ~p;
      end
    end
    return {idx & {12{p}}, b};
  endfunction : ecc_pos

  // Start one write strobe on the NAND pins
  function automatic nsq_top_st_t wr_go(input nsq_top_st_t s, input logic [15:0] v,
                                        input logic c, input logic a);
    nsq_top_st_t r;
    r = s;
    r.ph = 2'd1;
    r.tmr = 5'(PULSE_CYC - 1);
    r.we_n = 1'b0;
    r.doe = 1'b1;
    r.dout = v;
    r.cle = c;
    r.ale = a;
    return r;
  endfunction : wr_go

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    n = q;
    done = 1'b0;
    s_we = 1'b0;
    s_wa = 12'h000;
    s_wd = 16'h0000;
    f_in_v = 1'b0;
    f_in_d = 16'h0000;
    f_out_r = 1'b0;
    n.rb_m = nand_rb_in;
    n.rb_s = q.rb_m;
    n.din_m = nand_d_in;
    n.din_s = q.din_m;
    words = 13'((PAGE_MIN_BYTES << q.psel) >> q.w16);
    prog = q.cmd[F_PROG];
    xfer = q.cmd[F_DATA];
    sample = q.w16 ? q.din_s : {8'h00, q.din_s[7:0]};
    abyte = (q.aidx == ADDR5_IDX) ? q.addr5 : q.dat[{q.aidx[1:0], 3'b000} +: 8];
    after_addr = (xfer && prog) ? S_WDATA : (q.cmd[F_OP2_VALID] ? S_OP2 : S_WAIT);

    // Bus address phase
    aph = hsel_in && htrans_in[1] && hready_in;
    if (haddr_in[31:27] == CMD_WIN_TAG) begin
      kind = K_CMD;
    end else if (haddr_in[31:14] == SRAM_TAG) begin
      kind = K_SRAM;
    end else if (haddr_in[31:8] == REG_PAGE) begin
      kind = K_REG;
    end else begin
      kind = K_NONE;
    end
    bus_sram = (q.dp_wr && q.dp_kind == K_SRAM) || (aph && !hwrite_in && kind == K_SRAM);
    n.dp_wr = aph && hwrite_in;
    n.dp_kind = aph ? kind : K_NONE;
    n.dp_addr = haddr_in;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
    n.hrdata = 32'h0000_0000;
    if (aph && !hwrite_in) begin
      case (kind)
        K_CMD: begin
          n.hrdata[ST_BUSY] = (q.st != S_IDLE) || q.pend;
          n.hrdata[ST_PEND] = q.pend;
          n.hrdata[ST_OVF] = q.ovf;
          n.hrdata[ST_RB] = q.rb_s;
          n.ovf = 1'b0;
        end
        K_SRAM: n.hrdata = {16'h0000, sram_mem[haddr_in[13:2]]};
        K_REG: begin
          case (haddr_in)
            REG_BANK: n.hrdata = {29'h0, q.bank};
            REG_CFG: n.hrdata = {29'h0, q.w16, q.psel};
            REG_ADDR5: n.hrdata = {24'h0, q.addr5};
            REG_ECC_REF: n.hrdata = {16'h0000, q.ecc_ref};
            REG_ECC: n.hrdata = {16'h0000, q.ecc};
            default: n.hrdata = 32'h0000_0000;
          endcase
        end
        default: n.hrdata = 32'h0000_0000;
      endcase
    end

    // ****************************************
    // Strobe timing
    // ****************************************
    if (q.tmr != 5'd0) begin
      n.tmr = q.tmr - 5'd1;
    end else if (q.ph == 2'd1) begin
      n.we_n = 1'b1;
      n.re_n = 1'b1;
      n.ph = 2'd2;
      n.tmr = 5'(PULSE_CYC - 1);
      if (q.st == S_RDATA) begin
        f_in_v = 1'b1;
        f_in_d = sample;
        n.ecc = q.ecc ^ ecc_pos(q.ncnt[11:0], sample);
      end
    end else if (q.ph == 2'd2) begin
      done = 1'b1;
      n.ph = 2'd0;
      n.doe = 1'b0;
      n.cle = 1'b0;
      n.ale = 1'b0;
    end

    // ****************************************
    // Sequencer
    // ****************************************
    case (q.st)
      S_IDLE: begin
        if (q.pend) begin
          n.pend = 1'b0;
          n.cmd = q.pend_cmd;
          n.dat = q.pend_dat;
          n.anum = (q.pend_cmd[F_NADDR +: 3] > MAX_ADDR) ? MAX_ADDR : q.pend_cmd[F_NADDR +: 3];
          n.aidx = 3'h0;
          n.ncnt = 13'h0000;
          n.scnt = 13'h0000;
          n.ce_n = ~(NBANK'(1) << q.bank);
          n.st = S_OP1;
          if (q.pend_cmd[F_DATA]) begin
            n.ecc = ECC_RST;
          end
        end
      end
      S_OP1: begin
        if (done) begin
          n.st = (q.anum != 3'h0) ? S_ADDR : after_addr;
        end else if (q.ph == 2'd0 && q.tmr == 5'd0) begin
          n = wr_go(n, {8'h00, q.cmd[F_OP1 +: 8]}, 1'b1, 1'b0);
        end
      end
      S_ADDR: begin
        if (done) begin
          n.aidx = q.aidx + 3'h1;
          if (q.aidx + 3'h1 == q.anum) begin
            n.st = after_addr;
          end
        end else if (q.ph == 2'd0 && q.tmr == 5'd0) begin
          n = wr_go(n, {8'h00, abyte}, 1'b0, 1'b1);
        end
      end
      S_WDATA: begin
        if (done) begin
          n.ncnt = q.ncnt + 13'h0001;
          if (q.ncnt + 13'h0001 == words) begin
            n.st = q.cmd[F_OP2_VALID] ? S_OP2 : S_WAIT;
          end
        end else if (q.ph == 2'd0 && q.tmr == 5'd0 && f_out_v) begin
          f_out_r = 1'b1;
          n = wr_go(n, f_out_d, 1'b0, 1'b0);
          n.ecc = q.ecc ^ ecc_pos(q.ncnt[11:0], f_out_d);
        end
      end
      S_OP2: begin
        if (done) begin
          n.st = S_WAIT;
        end else if (q.ph == 2'd0 && q.tmr == 5'd0) begin
          n = wr_go(n, {8'h00, q.cmd[F_OP2 +: 8]}, 1'b1, 1'b0);
        end
      end
      S_WAIT: begin
        if (q.tmr == 5'd0 && q.rb_s) begin
          n.st = (xfer && !prog) ? S_RDATA : S_IDLE;
        end
      end
      S_RDATA: begin
        if (done) begin
          n.ncnt = q.ncnt + 13'h0001;
          if (q.ncnt + 13'h0001 == words) begin
            n.st = S_DRAIN;
          end
        end else if (q.ph == 2'd0 && q.tmr == 5'd0 && f_in_r) begin
          n.ph = 2'd1;
          n.tmr = 5'(PULSE_CYC - 1);
          n.re_n = 1'b0;
        end
      end
      S_DRAIN: begin
        if (q.scnt == words) begin
          n.ecc = q.ecc ^ q.ecc_ref;
          n.st = S_IDLE;
        end
      end
      default: n.st = S_IDLE;
    endcase
    if (n.st == S_WAIT && q.st != S_WAIT) begin
      n.tmr = 5'(WB_CYC - 1);
    end
    if (n.st == S_IDLE) begin
      n.ce_n = '1;
    end

    // SRAM to FIFO feed for programs, FIFO to SRAM for reads
    if (xfer && prog && !bus_sram && q.scnt < words &&
        (q.st == S_OP1 || q.st == S_ADDR || q.st == S_WDATA)) begin
      f_in_v = 1'b1;
      f_in_d = sram_mem[q.scnt[11:0]];
      if (f_in_r) begin
        n.scnt = q.scnt + 13'h0001;
      end
    end
    if (xfer && !prog && !bus_sram && (q.st == S_RDATA || q.st == S_DRAIN)) begin
      f_out_r = 1'b1;
      if (f_out_v) begin
        s_we = 1'b1;
        s_wa = q.scnt[11:0];
        s_wd = f_out_d;
        n.scnt = q.scnt + 13'h0001;
      end
    end

    // Bus data phase writes
    if (q.dp_wr) begin
      case (q.dp_kind)
        K_CMD: begin
          if (n.pend) begin
            n.ovf = 1'b1;
          end else begin
            n.pend = 1'b1;
            n.pend_cmd = q.dp_addr;
            n.pend_dat = hwdata_in;
          end
        end
        K_REG: begin
          case (q.dp_addr)
            REG_BANK: n.bank = hwdata_in[2:0];
            REG_CFG: {n.w16, n.psel} = hwdata_in[2:0];
            REG_ADDR5: n.addr5 = hwdata_in[7:0];
            REG_ECC_REF: n.ecc_ref = hwdata_in[15:0];
            default: n.bank = q.bank;
          endcase
        end
        K_SRAM: begin
          s_we = 1'b1;
          s_wa = q.dp_addr[13:2];
          s_wd = hwdata_in[15:0];
        end
        default: n.bank = q.bank;
      endcase
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
      q.hreadyout <= 1'b1;
      q.bank <= BANK_RST;
      q.ecc <= ECC_RST;
      q.we_n <= 1'b1;
      q.re_n <= 1'b1;
      q.ce_n <= '1;
    end else if (ce_in) begin
      q <= n;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (ce_in && s_we) begin
      sram_mem[s_wa] <= s_wd;
    end
  end

  nsq_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .in_valid_in(f_in_v),
    .in_ready_out(f_in_r),
    .in_data_in(f_in_d),
    .out_valid_out(f_out_v),
    .out_ready_in(f_out_r),
    .out_data_out(f_out_d)
  );

  assign hrdata_out = q.hrdata;
  assign hreadyout_out = q.hreadyout;
  assign hresp_out = q.hresp;
  assign nand_cle_out = q.cle;
  assign nand_ale_out = q.ale;
  assign nand_we_n_out = q.we_n;
  assign nand_re_n_out = q.re_n;
  assign nand_ce_n_out = q.ce_n;
  assign nand_d_out = q.dout;
  assign nand_d_oe_out = q.doe;
endmodule : nsq_top

// ### bench/nsq_top_props.sv
// Concurrent checks on the NAND command sequencer ports
`timescale 1ns/1ps

module nsq_top_props import nsq_pkg::*; #(
  parameter int NBANK = 8
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic nand_cle_out,
  input wire logic nand_ale_out,
  input wire logic nand_we_n_out,
  input wire logic nand_re_n_out,
  input wire logic [NBANK-1:0] nand_ce_n_out,
  input wire logic [15:0] nand_d_out,
  input wire logic nand_d_oe_out
);
  default clocking @(posedge sys_clk_in); endclocking
  // Frozen cycles stretch strobes, so checks pause then
  default disable iff (!rstn_in || !ce_in);
  logic cmd_wr;
  logic idle;
  assign cmd_wr = hsel_in && htrans_in[1] && hready_in && hwrite_in && haddr_in[31:27] == CMD_WIN_TAG;
  assign idle = &nand_ce_n_out;
  a_zero_wait: assert property (hreadyout_out)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp_out)
    else $error("error response");
  a_cmd_launch: assert property (cmd_wr && idle |-> ##3 !idle ##1 nand_cle_out)
    else $error("command not launched");
  a_we_width: assert property ($fell(nand_we_n_out) |-> !nand_we_n_out [*4] ##1 nand_we_n_out [*4])
    else $error("write strobe width");
  a_re_width: assert property ($fell(nand_re_n_out) |-> !nand_re_n_out [*4] ##1 nand_re_n_out [*4])
    else $error("read strobe width");
  a_dout_hold: assert property ($fell(nand_we_n_out) |-> ##1 $stable(nand_d_out) [*3])
    else $error("data moved in strobe");
  a_latch_excl: assert property (!(nand_cle_out && nand_ale_out))
    else $error("command and address latch together");
  a_latch_drive: assert property (nand_cle_out || nand_ale_out |-> nand_d_oe_out && !idle)
    else $error("latch cycle not driven");
  a_one_bank: assert property (!idle |-> $onehot(~nand_ce_n_out))
    else $error("several banks selected");
  c_cmd: cover property ($rose(nand_cle_out));
  c_addr: cover property ($rose(nand_ale_out));
  c_read: cover property ($fell(nand_re_n_out));
endmodule : nsq_top_props

bind nsq_top nsq_top_props #(.NBANK(NBANK)) u_nsq_top_props (
  .sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in),
  .ce_in(ce_in),
  .hsel_in(hsel_in),
  .haddr_in(haddr_in),
  .htrans_in(htrans_in),
  .hwrite_in(hwrite_in),
  .hready_in(hready_in),
  .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out),
  .nand_cle_out(nand_cle_out),
  .nand_ale_out(nand_ale_out),
  .nand_we_n_out(nand_we_n_out),
  .nand_re_n_out(nand_re_n_out),
  .nand_ce_n_out(nand_ce_n_out),
  .nand_d_out(nand_d_out),
  .nand_d_oe_out(nand_d_oe_out)
);

// ### bench/nsq_nand_model.sv
// Behavioural NAND flash device on the sequencer's far side
`timescale 1ns/1ps

module nsq_nand_model #(
  parameter int BUSY_CYC = 30
) (
  input wire logic clk_in,
  input wire logic cle_in,
  input wire logic ale_in,
  input wire logic we_n_in,
  input wire logic re_n_in,
  input wire logic [7:0] ce_n_in,
  input wire logic [15:0] d_in,
  output logic [15:0] d_out,
  output logic rb_out
);
  logic [7:0] mem [0:4095];
  logic [7:0] cmds [$];
  logic [7:0] addrs [$];
  logic [15:0] last = 16'h0000;
  logic sel;
  int widx = 0;
  int ridx = 0;
  int busy = 0;
  assign sel = !(&ce_n_in);
  always @(posedge we_n_in) begin
    if (sel && cle_in) begin
      cmds.push_back(d_in[7:0]);
      if (d_in[7:0] == 8'h80) widx = 0;
      if (d_in[7:0] == 8'h30) ridx = 0;
      if (d_in[7:0] inside {8'h10, 8'h30, 8'hFF}) busy = BUSY_CYC;
    end else if (sel && ale_in) begin
      addrs.push_back(d_in[7:0]);
    end else if (sel) begin
      mem[widx] = d_in[7:0];
      widx++;
    end
  end
  always @(posedge re_n_in) begin
    if (sel) ridx++;
  end
  // Released bus toggles every cycle
  always @(posedge clk_in) begin
    if (busy > 0) busy--;
    if (re_n_in) last <= ~last;
  end
  assign rb_out = (busy == 0);
  assign d_out = (!re_n_in && sel) ? {8'h00, mem[ridx]} : last;
endmodule : nsq_nand_model

// ### bench/tb_nsq_top.sv
// Self-checking bench for the NAND command sequencer
`timescale 1ns/1ps

module tb_nsq_top import nsq_pkg::*; ;
  logic clk, rstn, ce, hsel, hwrite, rb, hrdy, hresp, cle, ale, we_n, re_n, oe;
  logic [1:0] htrans;
  logic [7:0] ce_n;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [15:0] dout, mdl_d, bus_d;
  int err_total = 0;
  int n_tests = 0;
  assign bus_d = oe ? dout : mdl_d;
  nsq_top u_nsq_top (.sys_clk_in(clk), .rstn_in(rstn), .ce_in(ce), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hrdy), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .nand_cle_out(cle), .nand_ale_out(ale),
    .nand_we_n_out(we_n), .nand_re_n_out(re_n), .nand_ce_n_out(ce_n), .nand_d_in(bus_d),
    .nand_d_out(dout), .nand_d_oe_out(oe), .nand_rb_in(rb));
  nsq_nand_model u_nsq_nand_model (.clk_in(clk), .cle_in(cle), .ale_in(ale), .we_n_in(we_n),
    .re_n_in(re_n), .ce_n_in(ce_n), .d_in(bus_d), .d_out(mdl_d), .rb_out(rb));
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1; haddr <= a; htrans <= 2'h2; hwrite <= 1'h1;
    do @(posedge clk); while (hrdy !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'h1);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'h1; haddr <= a; htrans <= 2'h2; hwrite <= 1'h0;
    do @(posedge clk); while (hrdy !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0;
    do @(posedge clk); while (hrdy !== 1'h1);
    d = hrdata;
  endtask : rd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    while (s[0] !== 1'h0) rd(32'h6FFFFFFC, s);
  endtask : wait_idle
  function automatic logic [7:0] pat(input int i);
    return 8'(i) ^ 8'hC3;
  endfunction : pat
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    rstn = 1'h0; hsel = 1'h0; htrans = 2'h0; hwrite = 1'h0; haddr = 32'h0; hwdata = 32'h0;
    ce = 1'h1;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    rd(REG_BANK, v);
    chk("bank reset", 32'h0, v);
    rd(REG_ECC, v);
    chk("parity reset", 32'h0, v);
    wr(REG_BANK, 32'h3);
    wr(REG_ECC, 32'hFFFF);
    rd(REG_ECC, v);
    chk("parity read only", 32'h0, v);
    rd(REG_BANK, v);
    chk("bank", 32'h3, v);
    rd(32'h400E0040, v);
    chk("unmapped", 32'h0, v);
    wr(REG_CFG, 32'h0);
    wr(REG_ADDR5, 32'h5A);
    for (int i = 0; i < 512; i++) wr(32'h20100000 + 32'(4 * i), {24'h0, pat(i)});
    wr(32'h683B1080, 32'h44332211);
    rd(32'h68000000, v);
    chk("busy", 32'h1, {31'h0, v[0]});
    chk("bank select", 32'hF7, {24'h0, ce_n});
    ce <= 1'h0;
    @(posedge clk);
    v = {19'h0, cle, ale, we_n, re_n, oe, ce_n};
    repeat (12) @(posedge clk);
    chk("clock enable hold", v, {19'h0, cle, ale, we_n, re_n, oe, ce_n});
    ce <= 1'h1;
    wait_idle();
    chk("program words", 32'h200, 32'(u_nsq_nand_model.widx));
    chk("cmd a", 32'h80, {24'h0, u_nsq_nand_model.cmds[0]});
    chk("cmd b", 32'h10, {24'h0, u_nsq_nand_model.cmds[1]});
    for (int i = 0; i < 5; i++) chk("addr", 32'h11 * (i + 1) + (i == 4 ? 32'h5 : 32'h0),
      {24'h0, u_nsq_nand_model.addrs[i]});
    chk("page byte", {24'h0, pat(511)}, {24'h0, u_nsq_nand_model.mem[511]});
    rd(REG_ECC, v);
    wr(REG_ECC_REF, v);
    u_nsq_nand_model.mem[37] = u_nsq_nand_model.mem[37] ^ 8'h20;
    wr(32'h6FDB3000, 32'h44332211);
    wait_idle();
    chk("cmd c", 32'h30, {24'h0, u_nsq_nand_model.cmds[3]});
    rd(REG_ECC, v);
    chk("error location", 32'h255, v);
    rd(32'h20100000 + 32'h94, v);
    chk("sram flipped", {24'h0, pat(37) ^ 8'h20}, v);
    rd(32'h20100000 + 32'h7FC, v);
    chk("sram last", {24'h0, pat(511)}, v);
    for (int i = 0; i < 3; i++) wr(32'h680000FF, 32'h0);
    rd(32'h68000000, v);
    chk("overflow", 32'h4, {29'h0, v[2], 2'h0});
    rd(32'h68000000, v);
    chk("overflow clear", 32'h0, {29'h0, v[2], 2'h0});
    wait_idle();
    chk("cmd count", 32'h6, 32'(u_nsq_nand_model.cmds.size()));
    final_report();
  end
endmodule : tb_nsq_top
